// ---- dsmd_decoder.v ----
// data space memory decoder top
`include "dsmd_regs.vh"
// Summary of operation
// - data addresses 0 to fff select the i/o register bus for loads and stores.
// - a mapped eeprom sits from 1000 upward, ending at 17ff at the most, sized by a parameter.
// - sram starts at 2000 and external memory fills everything above sram up to ffffff.
// - addresses between the end of eeprom and 2000 hit no storage and are flagged as a hole.
// - every space is decoded from a plain linear address with no bank or page select.
// - direct i/o ops reach i/o addresses 0 to 3f only.
// - i/o addresses 0 to 1f accept bit set, bit clear and skip-on-bit tests.
// - eeprom accesses may be single bytes or whole pages.
// - each flash address selects one 16-bit word.
// - a flash store only takes effect when issued from the boot section.
// - lock settings block writes, or reads and writes, to a flash section.
// - dma may read eeprom but never write it and never reach flash.
// - the dma shares the cpu data bus through deterministic arbitration.
// - i/o, eeprom, sram and external memory each have their own select and arbiter but share one address, op and data bus.
module dsmd_decoder #(
  parameter EE_SIZE = 24'h000800,
  parameter SRAM_SIZE = 24'h001000,
  parameter EE_PAGE = 6'h20,
  parameter FLASH_AW = 17,
  parameter BOOT_BASE = 17'h10000
) (
  input wire sys_clk,
  input wire resetn,
  input wire cpuValid,
  input wire [23:0] cpuAddr,
  input wire [2:0] cpuOp,
  input wire [2:0] cpuBit,
  input wire cpuDirect,
  input wire cpuPage,
  input wire [7:0] cpuWdata,
  input wire dmaValid,
  input wire [23:0] dmaAddr,
  input wire dmaWrite,
  input wire [7:0] dmaWdata,
  input wire flashValid,
  input wire flashDma,
  input wire flashWrite,
  input wire [FLASH_AW-1:0] flashAddr,
  input wire [FLASH_AW-1:0] flashPc,
  input wire [15:0] flashWdata,
  input wire [1:0] appLock,
  input wire [1:0] bootLock,
  output reg [3:0] busSel,
  output reg [23:0] busAddr,
  output reg [2:0] busOp,
  output reg [7:0] busBitMask,
  output reg busPage,
  output reg [7:0] busWdata,
  output reg busFromDma,
  output reg cpuStall,
  output reg dmaStall,
  output reg accessError,
  output reg flashGo,
  output reg flashWr,
  output reg [FLASH_AW-1:0] flashWordAddr,
  output reg [15:0] flashData,
  output reg flashBlocked
);
  // -------------------------------------------------------
  // window limits
  // -------------------------------------------------------
  localparam [23:0] EE_CAP = `DSMD_EE_MAX_LAST + 24'h000001;
  localparam [23:0] EE_END = (`DSMD_EE_BASE + EE_SIZE > EE_CAP) ? EE_CAP : `DSMD_EE_BASE + EE_SIZE;
  localparam [23:0] SRAM_END = `DSMD_SRAM_BASE + SRAM_SIZE;
  // -------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------
  function [2:0] dsmdTarget;
    input [23:0] a;
    begin
      if (a <= `DSMD_IO_LAST)
        dsmdTarget = `DSMD_TGT_IO;
      else if (a < EE_END)
        dsmdTarget = `DSMD_TGT_EE;
      else if (a < `DSMD_SRAM_BASE)
        dsmdTarget = `DSMD_TGT_HOLE;
      else if (a < SRAM_END)
        dsmdTarget = `DSMD_TGT_SRAM;
      else
        dsmdTarget = `DSMD_TGT_EXT;
    end
  endfunction
  function isWriteOp;
    input [2:0] op;
    begin
      isWriteOp = (op == `DSMD_OP_STORE) | (op == `DSMD_OP_BITSET) | (op == `DSMD_OP_BITCLR);
    end
  endfunction
  function [3:0] tgtOneHot;
    input [2:0] t;
    begin
      case (t)
        `DSMD_TGT_IO: tgtOneHot = 4'h1;
        `DSMD_TGT_EE: tgtOneHot = 4'h2;
        `DSMD_TGT_SRAM: tgtOneHot = 4'h4;
        `DSMD_TGT_EXT: tgtOneHot = 4'h8;
        default: tgtOneHot = 4'h0;
      endcase
    end
  endfunction
  wire [2:0] cpuTgt = dsmdTarget(cpuAddr);
  wire [2:0] dmaTgt = dsmdTarget(dmaAddr);
  wire [3:0] cpuHot = tgtOneHot(cpuTgt);
  wire [3:0] dmaHot = tgtOneHot(dmaTgt);
  wire isBitOp = (cpuOp >= `DSMD_OP_BITSET) && (cpuOp <= `DSMD_OP_SKIPCLR);
  // -------------------------------------------------------
  // cpu access legality
  // -------------------------------------------------------
  wire cpuBitBad = isBitOp & (cpuAddr > `DSMD_BIT_IO_LAST);
  wire cpuDirBad = cpuDirect & (cpuAddr > `DSMD_DIRECT_IO_LAST);
  wire cpuHole = cpuTgt == `DSMD_TGT_HOLE;
  wire cpuPageBad = cpuPage & (cpuTgt != `DSMD_TGT_EE);
  wire cpuBad = cpuValid & (cpuOp != `DSMD_OP_NONE) & (cpuBitBad | cpuDirBad | cpuHole | cpuPageBad);
  wire cpuLive = cpuValid & (cpuOp != `DSMD_OP_NONE) & ~cpuBad;
  // -------------------------------------------------------
  // dma access legality
  // -------------------------------------------------------
  wire dmaEeWr = dmaWrite & (dmaTgt == `DSMD_TGT_EE);
  wire dmaBad = dmaValid & (dmaEeWr | (dmaTgt == `DSMD_TGT_HOLE));
  wire dmaLive = dmaValid & ~dmaBad;
  // -------------------------------------------------------
  // per-bus arbitration
  // -------------------------------------------------------
  wire [3:0] cpuGnt;
  wire [3:0] dmaGnt;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gArb
      dsmd_arb uArb (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .cpuReq(cpuLive & cpuHot[g]),
        .dmaReq(dmaLive & dmaHot[g]),
        .cpuGnt(cpuGnt[g]),
        .dmaGnt(dmaGnt[g])
      );
    end
  endgenerate
  wire cpuWon = |cpuGnt;
  wire dmaWon = |dmaGnt;
  // -------------------------------------------------------
  // flash word path, boot-only store and locks
  // -------------------------------------------------------
  wire inBootPc = flashPc >= BOOT_BASE;
  wire inBootAddr = flashAddr >= BOOT_BASE;
  wire [1:0] lockSel = inBootAddr ? bootLock : appLock;
  wire lockHit = flashWrite ? (lockSel != `DSMD_LOCK_NONE) : (lockSel == `DSMD_LOCK_RW);
  wire spmBad = flashWrite & ~inBootPc;
  wire flashBad = flashValid & (flashDma | spmBad | lockHit);
  // -------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busSel <= 4'h0;
      busAddr <= 24'h000000;
      busOp <= `DSMD_OP_NONE;
      busBitMask <= 8'h00;
      busPage <= 1'b0;
      busWdata <= 8'h00;
      busFromDma <= 1'b0;
    end else begin
      // the cpu bus lane wins the shared output when both get separate buses
      busSel <= cpuGnt | dmaGnt;
      busFromDma <= dmaWon & ~cpuWon;
      if (cpuWon) begin
        busAddr <= cpuAddr;
        busOp <= cpuOp;
        busBitMask <= isBitOp ? (8'h01 << cpuBit) : 8'h00;
        busPage <= cpuPage;
        busWdata <= cpuWdata;
      end else if (dmaWon) begin
        busAddr <= dmaAddr;
        busOp <= dmaWrite ? `DSMD_OP_STORE : `DSMD_OP_LOAD;
        busBitMask <= 8'h00;
        busPage <= 1'b0;
        busWdata <= dmaWdata;
      end else begin
        busOp <= `DSMD_OP_NONE;
        busBitMask <= 8'h00;
        busPage <= 1'b0;
      end
    end
  end
  // -------------------------------------------------------
  // registered stall and error outputs
  // -------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpuStall <= 1'b0;
      dmaStall <= 1'b0;
      accessError <= 1'b0;
    end else begin
      // dma also stalls while the cpu holds the shared lanes
      cpuStall <= cpuLive & ~cpuWon;
      dmaStall <= dmaLive & (~dmaWon | cpuWon);
      accessError <= cpuBad | dmaBad;
    end
  end
  // -------------------------------------------------------
  // registered flash word outputs
  // -------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flashGo <= 1'b0;
      flashWr <= 1'b0;
      flashWordAddr <= {FLASH_AW{1'b0}};
      flashData <= 16'h0000;
      flashBlocked <= 1'b0;
    end else begin
      flashGo <= flashValid & ~flashBad;
      flashWr <= flashValid & ~flashBad & flashWrite;
      flashWordAddr <= flashAddr;
      flashData <= flashWdata;
      flashBlocked <= flashBad;
    end
  end
endmodule // dsmd_decoder

// ---- dsmd_regs.vh ----
// address map constants for the data space memory decoder
`ifndef DSMD_REGS_VH
`define DSMD_REGS_VH
`define DSMD_IO_BASE 24'h000000
`define DSMD_IO_LAST 24'h000fff
`define DSMD_EE_BASE 24'h001000
`define DSMD_EE_MAX_LAST 24'h0017ff
`define DSMD_SRAM_BASE 24'h002000
`define DSMD_EXT_LAST 24'hffffff
`define DSMD_DIRECT_IO_LAST 24'h00003f
`define DSMD_BIT_IO_LAST 24'h00001f
`define DSMD_TGT_IO 3'h0
`define DSMD_TGT_EE 3'h1
`define DSMD_TGT_SRAM 3'h2
`define DSMD_TGT_EXT 3'h3
`define DSMD_TGT_HOLE 3'h4
`define DSMD_OP_NONE 3'h0
`define DSMD_OP_LOAD 3'h1
`define DSMD_OP_STORE 3'h2
`define DSMD_OP_BITSET 3'h3
`define DSMD_OP_BITCLR 3'h4
`define DSMD_OP_SKIPSET 3'h5
`define DSMD_OP_SKIPCLR 3'h6
`define DSMD_LOCK_NONE 2'h0
`define DSMD_LOCK_WR 2'h1
`define DSMD_LOCK_RW 2'h2
`endif

// ---- dsmd_arb.v ----
// round-robin two-master arbiter for one target bus
module dsmd_arb (
  input wire sys_clk,
  input wire resetn,
  input wire cpuReq,
  input wire dmaReq,
  output wire cpuGnt,
  output wire dmaGnt
);
  reg lastDma_q;
  wire lastDma_d;
  // -------------------------------------------------------
  // grant: dma wins unless it won the previous contended cycle
  // -------------------------------------------------------
  assign dmaGnt = dmaReq & (~cpuReq | ~lastDma_q);
  assign cpuGnt = cpuReq & ~dmaGnt;
  assign lastDma_d = (cpuReq & dmaReq) ? dmaGnt : lastDma_q;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lastDma_q <= 1'b0;
    end else begin
      lastDma_q <= lastDma_d;
    end
  end
endmodule // dsmd_arb

// ---- dsmd_decoder_asserts.sv ----
// assertion checker for the data space memory decoder
module dsmd_decoder_asserts #(
  parameter FLASH_AW = 17,
  parameter BOOT_BASE = 17'h10000
) (
  input wire sys_clk, resetn, cpuValid, cpuDirect, cpuPage, dmaValid, dmaWrite,
  input wire flashValid, flashDma, flashWrite, cpuStall, dmaStall, accessError, flashGo, flashBlocked,
  input wire [23:0] cpuAddr, dmaAddr,
  input wire [2:0] cpuOp,
  input wire [FLASH_AW-1:0] flashPc,
  input wire [3:0] busSel
);
  wire plainLoad = cpuValid && cpuOp == 3'h1 && !cpuDirect && !cpuPage && !dmaValid;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_clash;
    cpuValid && cpuOp == 3'h1 && !cpuDirect && !cpuPage && dmaValid && cpuAddr[23:12] == 12'h002
      && dmaAddr[23:12] == 12'h002;
  endsequence
  property p_io; plainLoad && cpuAddr <= 24'hfff |=> busSel == 4'h1 && !accessError; endproperty
  a_io: assert property (p_io) else $error("io window");
  property p_ee; plainLoad && cpuAddr inside {[24'h1000:24'h17ff]} |=> busSel == 4'h2; endproperty
  a_ee: assert property (p_ee) else $error("eeprom window");
  property p_ram; plainLoad && cpuAddr[23:12] == 12'h002 |=> busSel == 4'h4; endproperty
  a_ram: assert property (p_ram) else $error("sram window");
  property p_ext; plainLoad && cpuAddr >= 24'h3000 |=> busSel == 4'h8; endproperty
  a_ext: assert property (p_ext) else $error("external window");
  property p_hole; plainLoad && cpuAddr inside {[24'h1800:24'h1fff]} |=> accessError && busSel == 4'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole");
  property p_dir; cpuValid && cpuOp != 3'h0 && cpuDirect && cpuAddr > 24'h3f |=> accessError; endproperty
  a_dir: assert property (p_dir) else $error("direct range");
  property p_bit; cpuValid && cpuOp inside {[3'h3:3'h6]} && cpuAddr > 24'h1f |=> accessError; endproperty
  a_bit: assert property (p_bit) else $error("bit range");
  property p_dee; dmaValid && dmaWrite && !cpuValid && dmaAddr[23:11] == 13'h02 |=> accessError && !busSel[1]; endproperty
  a_dee: assert property (p_dee) else $error("dma eeprom write");
  property p_fl; flashValid && (flashDma || flashWrite && flashPc < BOOT_BASE) |=> flashBlocked && !flashGo; endproperty
  a_fl: assert property (p_fl) else $error("flash block");
  property p_clash; s_clash |=> cpuStall != dmaStall; endproperty
  a_clash: assert property (p_clash) else $error("clash grant");
endmodule // dsmd_decoder_asserts
bind dsmd_decoder dsmd_decoder_asserts #(.FLASH_AW(FLASH_AW), .BOOT_BASE(BOOT_BASE)) u_chk (.*);

// ---- dsmd_dma_model.sv ----
// dma bus master model, re-presents while stalled
module dsmd_dma_model (
  input wire sys_clk,
  input wire dmaStall,
  output logic dmaValid,
  output logic dmaWrite,
  output logic [23:0] dmaAddr,
  output logic [7:0] dmaWdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {dmaValid, dmaWrite, dmaAddr, dmaWdata} = {2'h0, 24'h0, 8'ha5};
  task automatic send(input [23:0] a, input w, input [7:0] d);
    do begin
      @(posedge sys_clk);
      {dmaAddr, dmaWrite, dmaWdata, dmaValid} <= {a, w, d, 1'h1};
      @(posedge sys_clk);
      {dmaAddr, dmaWrite, dmaValid} <= {~a, 1'h0, 1'h0};
      #1;
    end while (dmaStall === 1'b1);
  endtask
endmodule // dsmd_dma_model

// ---- dsmd_decoder_tb.sv ----
// self-checking testbench for the data space memory decoder
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("wrong value %0t %h %h", $time, a, b); end end
module dsmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, resetn = 1'h0, cpuValid = 1'h0, cpuDirect = 1'h0, cpuPage = 1'h0;
  logic flashValid = 1'h0, flashDma = 1'h0, flashWrite = 1'h0;
  logic [23:0] cpuAddr = 24'h0;
  logic [2:0] cpuOp = 3'h0, cpuBit = 3'h5;
  logic [7:0] cpuWdata = 8'h3c;
  logic [16:0] flashAddr = 17'h1234, flashPc = 17'h0;
  logic [15:0] flashWdata = 16'hbeef;
  logic [1:0] appLock = 2'h0, bootLock = 2'h0;
  wire dmaValid, dmaWrite, busPage, busFromDma, cpuStall, dmaStall, accessError, flashGo, flashWr, flashBlocked;
  wire [23:0] dmaAddr, busAddr;
  wire [7:0] dmaWdata, busBitMask, busWdata;
  wire [3:0] busSel;
  wire [2:0] busOp;
  wire [16:0] flashWordAddr;
  wire [15:0] flashData;
  int failures = 0;
  int samples_checked = 0;
  dsmd_decoder u_dut (.*);
  dsmd_dma_model u_dma (.*);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic cpu(input [23:0] a, input [2:0] op, input [1:0] m, input [3:0] sel, input err);
    @(posedge sys_clk);
    {cpuAddr, cpuOp, cpuPage, cpuDirect, cpuValid} <= {a, op, m, 1'h1};
    @(posedge sys_clk);
    {cpuAddr, cpuValid} <= {~a, 1'h0};
    #1;
    `CHK({busSel, accessError}, {sel, err})
  endtask
  task automatic fl(input w, input d, input [16:0] pc, input [16:0] fa, input [3:0] lk, input go);
    @(posedge sys_clk);
    {flashValid, flashWrite, flashDma, flashPc, flashAddr, appLock, bootLock} <= {1'h1, w, d, pc, fa, lk};
    @(posedge sys_clk);
    flashValid <= 1'h0;
    #1;
    `CHK({flashGo, flashBlocked}, {go, !go})
    if (go) `CHK({flashWordAddr, flashWr, flashData}, {fa, w, 16'hbeef})
  endtask
  task automatic t_map;
    logic [23:0] a [10] = '{24'h0, 24'hfff, 24'h1000, 24'h17ff, 24'h1800,
      24'h1fff, 24'h2000, 24'h2fff, 24'h3000, 24'hffffff};
    logic [3:0] s [10] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h0, 4'h0, 4'h4, 4'h4, 4'h8, 4'h8};
    for (int i = 0; i < 10; i++) begin
      cpu(a[i], 3'h1, 2'h0, s[i], s[i] == 4'h0);
      if (s[i] != 4'h0) `CHK({busAddr, busOp, busFromDma}, {a[i], 3'h1, 1'h0})
    end
  endtask
  task automatic t_io;
    cpu(24'h3f, 3'h1, 2'h1, 4'h1, 1'h0);
    cpu(24'h40, 3'h1, 2'h1, 4'h0, 1'h1);
    for (int op = 3; op < 7; op++) begin
      cpu(24'h1f, op[2:0], 2'h0, 4'h1, 1'h0);
      `CHK({busBitMask, busOp}, {8'h20, op[2:0]})
      cpu(24'h20, op[2:0], 2'h0, 4'h0, 1'h1);
    end
    cpu(24'h1000, 3'h2, 2'h2, 4'h2, 1'h0);
    `CHK({busPage, busOp, busWdata}, {1'h1, 3'h2, 8'h3c})
    cpu(24'h2000, 3'h2, 2'h2, 4'h0, 1'h1);
  endtask
  task automatic t_flash;
    fl(1'h0, 1'h0, 17'h0, 17'h1234, 4'h0, 1'h1);
    fl(1'h1, 1'h0, 17'hffff, 17'h1234, 4'h0, 1'h0);
    fl(1'h1, 1'h0, 17'h10000, 17'h1234, 4'h0, 1'h1);
    fl(1'h0, 1'h1, 17'h10000, 17'h1234, 4'h0, 1'h0);
    fl(1'h1, 1'h0, 17'h10000, 17'h1234, 4'h4, 1'h0);
    fl(1'h0, 1'h0, 17'h0, 17'h1234, 4'h4, 1'h1);
    fl(1'h0, 1'h0, 17'h0, 17'h1234, 4'h8, 1'h0);
    fl(1'h0, 1'h0, 17'h0, 17'h10020, 4'h8, 1'h1);
    fl(1'h1, 1'h0, 17'h10000, 17'h10020, 4'h1, 1'h0);
  endtask
  task automatic t_dma;
    u_dma.send(24'h1000, 1'h0, 8'h00);
    `CHK({busSel, busFromDma, accessError}, 6'h0a)
    u_dma.send(24'h1000, 1'h1, 8'h00);
    `CHK({busSel, accessError}, 5'h01)
    u_dma.send(24'h20, 1'h1, 8'h5a);
    `CHK({busSel, busOp, busWdata, busAddr}, {4'h1, 3'h2, 8'h5a, 24'h20})
    fork
      u_dma.send(24'h2100, 1'h0, 8'h00);
      cpu(24'h10, 3'h1, 2'h0, 4'h5, 1'h0);
    join
    `CHK({busSel, busAddr, busFromDma, dmaStall}, {4'h4, 24'h2100, 1'h1, 1'h0})
    for (int i = 0; i < 2; i++) fork
      u_dma.send(24'h2100, 1'h0, 8'h00);
      begin
        cpu(24'h2000, 3'h1, 2'h0, 4'h4, 1'h0);
        `CHK({cpuStall, dmaStall}, i ? 2'h1 : 2'h2)
      end
    join
  endtask
  task automatic complete_run;
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    t_map();
    t_io();
    t_flash();
    t_dma();
    complete_run();
  end
endmodule // dsmd_decoder_tb
